// file: core/port_data_regs.sv
// data registers of three input-mostly pin groups with byte register access
`timescale 1ns/1ps
`default_nettype none
module port_data_regs #(
   parameter int GROUP_PINS = port_data_pkg::PIN_COUNT
) (
   input wire logic clk, // peripheral clock, 40 MHz
   input wire logic rst_b, // power-on reset, async, active low
   input wire port_data_pkg::bus_req_t bus_req, // byte register requests
   output port_data_pkg::bus_rsp_t bus_rsp, // registered answers
   input wire logic addr_xlate_off, // high when no address translation applies
   input wire logic [15:0] group_one_function_control, // two bits per pin
   input wire logic [15:0] group_two_function_control, // two bits per pin
   input wire logic [15:0] group_three_function_control, // two bits per pin
   input wire logic [7:0] group_one_pins, // raw pin levels
   input wire logic [7:0] group_two_pins, // raw pin levels
   input wire logic [7:0] group_three_pins, // raw pin levels, bit 7 is the bidir pin
   output logic group_three_bidir_pin_out, // level driven on the bidir pin
   output logic group_three_bidir_pin_oe_b, // low while the bidir pin is driven
   output logic [7:0] group_one_pullup_en, // pull-up enables
   output logic [7:0] group_two_pullup_en, // pull-up enables
   output logic [7:0] group_three_pullup_en // pull-up enables
);
   import port_data_pkg::*;

   // ======================================================================
   // elaboration check
   // every address holds one byte, so the group size is fixed
   if (GROUP_PINS != PIN_COUNT) begin : g_pins_check
      $error("port_data_regs supports exactly eight pins per group");
   end

   // ======================================================================
   // helpers
   // pick the two-bit function code of pin n
   function automatic logic [1:0] fn_code(input logic [15:0] ctrl, input int n);
      logic [1:0] code;
      code = ctrl[n*FN_FIELD_WIDTH +: FN_FIELD_WIDTH];
      return code;
   endfunction : fn_code

   // true for either input code (upper function bit set)
   function automatic logic is_input(input logic [1:0] code);
      logic res;
      res = (code == FN_INPUT_PULLUP) || (code == FN_INPUT_PLAIN);
      return res;
   endfunction : is_input

   // ======================================================================
   // synchronised pins
   logic [7:0] g1_sync; // group one levels after two flops
   logic [7:0] g2_sync; // group two levels after two flops
   logic [7:0] g3_sync; // group three levels after two flops

   // pins come from outside, so each passes two flops first
   pin_sync #(.WIDTH(8)) u_sync_one (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(group_one_pins),
      .sync_out(g1_sync)
   );

   pin_sync #(.WIDTH(8)) u_sync_two (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(group_two_pins),
      .sync_out(g2_sync)
   );

   pin_sync #(.WIDTH(8)) u_sync_three (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(group_three_pins),
      .sync_out(g3_sync)
   );

   // ======================================================================
   // address decode
   logic alias_hit_ok; // alias region is decoded
   logic sel_one; // request targets group one
   logic sel_two; // request targets group two
   logic sel_three; // request targets group three
   logic req_any; // a read or write strobe this cycle

   // physical address always, alias only without translation
   always_comb begin
      alias_hit_ok = addr_xlate_off && ((bus_req.addr & ~PHYS_ADDR_MASK) == ALIAS_REGION_BITS);
      sel_one = (bus_req.addr == ADDR_GROUP_ONE) ||
         (alias_hit_ok && ((bus_req.addr & PHYS_ADDR_MASK) == ADDR_GROUP_ONE));
      sel_two = (bus_req.addr == ADDR_GROUP_TWO) ||
         (alias_hit_ok && ((bus_req.addr & PHYS_ADDR_MASK) == ADDR_GROUP_TWO));
      sel_three = (bus_req.addr == ADDR_GROUP_THREE) ||
         (alias_hit_ok && ((bus_req.addr & PHYS_ADDR_MASK) == ADDR_GROUP_THREE));
      req_any = bus_req.rd || bus_req.wr;
   end

   // ======================================================================
   // group three stored bit
   logic bidir_r; // group_three_bidir_bit storage
   logic bidir_out_mode; // bidir pin set to general output

   assign bidir_out_mode = (fn_code(group_three_function_control, BIDIR_BIT) == FN_OUTPUT);

   // only the power-on reset touches it; a manual reset or sleep never reaches here
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bidir_r <= BIDIR_RESET;
      end else if (bus_req.wr && sel_three) begin
         // stored in every mode, the pin only follows in output mode
         bidir_r <= bus_req.wdata[BIDIR_BIT];
      end
   end

   // ======================================================================
   // read values per bit
   logic [7:0] g1_read; // group one read view
   logic [7:0] g2_read; // group two read view
   logic [7:0] g3_read; // group three read view

   // input-only bits: pin level in input modes, low otherwise
   for (genvar n = 0; n < 8; n++) begin : g_read_bits
      // group one and two are read-only; no write path exists for them
      assign g1_read[n] = is_input(fn_code(group_one_function_control, n)) ? g1_sync[n] : 1'b0;
      assign g2_read[n] = is_input(fn_code(group_two_function_control, n)) ? g2_sync[n] : 1'b0;
      if (n == BIDIR_BIT) begin : g_bidir
         // stored bit for output and alternate, pin level for inputs
         assign g3_read[n] = is_input(fn_code(group_three_function_control, n)) ? g3_sync[n] : bidir_r;
      end else begin : g_input_only
         assign g3_read[n] = is_input(fn_code(group_three_function_control, n)) ? g3_sync[n] : 1'b0;
      end
   end

   // ======================================================================
   // bus answer
   // answer one cycle after every strobe; unmapped reads give zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_rsp.ack <= 1'b0;
      end else begin
         bus_rsp.ack <= req_any;
      end
   end

   // read data held between reads, so a slow master may sample late
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_rsp.rdata <= RDATA_RESET;
      end else if (bus_req.rd) begin
         if (sel_one) begin
            bus_rsp.rdata <= g1_read;
         end else if (sel_two) begin
            bus_rsp.rdata <= g2_read;
         end else if (sel_three) begin
            bus_rsp.rdata <= g3_read;
         end else begin
            bus_rsp.rdata <= UNMAPPED_RDATA;
         end
      end
   end
   // writes to groups one and two and to bits 6..0 of group three fall on the floor

   // ======================================================================
   // pin drive and pull-ups
   logic [7:0] pu_one_nxt; // next pull-up enables, group one
   logic [7:0] pu_two_nxt; // next pull-up enables, group two
   logic [7:0] pu_three_nxt; // next pull-up enables, group three

   // pull-up follows the input-with-pull-up code on each pin
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         pu_one_nxt[n] = (fn_code(group_one_function_control, n) == FN_INPUT_PULLUP);
         pu_two_nxt[n] = (fn_code(group_two_function_control, n) == FN_INPUT_PULLUP);
         pu_three_nxt[n] = (fn_code(group_three_function_control, n) == FN_INPUT_PULLUP);
      end
   end

   // registered enables; reset leaves every pull-up on
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         group_one_pullup_en <= PULLUP_RESET;
         group_two_pullup_en <= PULLUP_RESET;
         group_three_pullup_en <= PULLUP_RESET;
      end else begin
         group_one_pullup_en <= pu_one_nxt;
         group_two_pullup_en <= pu_two_nxt;
         group_three_pullup_en <= pu_three_nxt;
      end
   end

   // bidir pin drives the stored bit in output mode only
   // the level is the register itself, so it is glitch free
   assign group_three_bidir_pin_out = bidir_r;
   assign group_three_bidir_pin_oe_b = ~bidir_out_mode;
   // the five io-capable pins of group two are driven by neighbouring logic
   // software keeps these accesses uncached; nothing here depends on it

   // ======================================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // a read request aimed at one of the three group registers
   sequence s_read_one;
      bus_req.rd && sel_one;
   endsequence

   sequence s_read_three;
      bus_req.rd && sel_three;
   endsequence

   sequence s_read_two;
      bus_req.rd && sel_two;
   endsequence

   property p_ack_next;
      req_any |=> bus_rsp.ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("strobe not answered next cycle");

   property p_no_spurious_ack;
      !req_any |=> !bus_rsp.ack;
   endproperty
   a_no_spurious_ack: assert property (p_no_spurious_ack) else $error("answer without strobe");

   property p_grp1_level;
      (s_read_one and is_input(fn_code(group_one_function_control, 0)))
         |=> bus_rsp.rdata[0] == $past(g1_sync[0]);
   endproperty
   a_grp1_level: assert property (p_grp1_level) else $error("group one input bit not pin level");

   property p_grp1_reserved;
      (s_read_one and fn_code(group_one_function_control, 1) == FN_OUTPUT) |=> bus_rsp.rdata[1] == 1'b0;
   endproperty
   a_grp1_reserved: assert property (p_grp1_reserved) else $error("reserved code read not zero");

   property p_grp3_readback;
      (s_read_three and bidir_out_mode) |=> bus_rsp.rdata[BIDIR_BIT] == $past(bidir_r);
   endproperty
   a_grp3_readback: assert property (p_grp3_readback) else $error("output mode read not stored bit");

   property p_grp3_low_bits;
      (s_read_three and !is_input(fn_code(group_three_function_control, 0))) |=> bus_rsp.rdata[0] == 1'b0;
   endproperty
   a_grp3_low_bits: assert property (p_grp3_low_bits) else $error("group three input bit not low");

   // the written bit lands in storage and on the pin level at once
   property p_grp3_store;
      (bus_req.wr && sel_three) |=> bidir_r == $past(bus_req.wdata[BIDIR_BIT])
         && group_three_bidir_pin_out == $past(bus_req.wdata[BIDIR_BIT]);
   endproperty
   a_grp3_store: assert property (p_grp3_store) else $error("group three write not stored");

   property p_input_write_void;
      (bus_req.wr && !sel_three) |=> $stable(bidir_r);
   endproperty
   a_input_write_void: assert property (p_input_write_void) else $error("stray write changed stored bit");

   property p_drive;
      bidir_out_mode |-> !group_three_bidir_pin_oe_b && group_three_bidir_pin_out == bidir_r;
   endproperty
   a_drive: assert property (p_drive) else $error("bidir pin not driven in output mode");

   property p_alias_blocked;
      (bus_req.rd && !addr_xlate_off && bus_req.addr == (ADDR_GROUP_ONE | ALIAS_REGION_BITS))
         |=> bus_rsp.rdata == UNMAPPED_RDATA;
   endproperty
   a_alias_blocked: assert property (p_alias_blocked) else $error("alias decoded under translation");

   // group two input bit shows the synced pin
   property p_grp2_level;
      (s_read_two and is_input(fn_code(group_two_function_control, 7)))
         |=> bus_rsp.rdata[7] == $past(g2_sync[7]);
   endproperty
   a_grp2_level: assert property (p_grp2_level) else $error("group two input bit not pin level");

   // reserved code on a group two pin reads low
   property p_grp2_reserved;
      (s_read_two and fn_code(group_two_function_control, 0) == FN_OUTPUT) |=> bus_rsp.rdata[0] == 1'b0;
   endproperty
   a_grp2_reserved: assert property (p_grp2_reserved) else $error("group two reserved read not zero");

   // alternate code on an input-only pin reads low
   property p_grp1_alt;
      (s_read_one and fn_code(group_one_function_control, 2) == FN_ALTERNATE) |=> bus_rsp.rdata[2] == 1'b0;
   endproperty
   a_grp1_alt: assert property (p_grp1_alt) else $error("group one alternate read not zero");

   // same for group two, another bit
   property p_grp2_alt;
      (s_read_two and fn_code(group_two_function_control, 3) == FN_ALTERNATE) |=> bus_rsp.rdata[3] == 1'b0;
   endproperty
   a_grp2_alt: assert property (p_grp2_alt) else $error("group two alternate read not zero");

   // bidir pin in an input mode reads the synced pin
   property p_grp3_pin;
      (s_read_three and is_input(fn_code(group_three_function_control, BIDIR_BIT)))
         |=> bus_rsp.rdata[BIDIR_BIT] == $past(g3_sync[BIDIR_BIT]);
   endproperty
   a_grp3_pin: assert property (p_grp3_pin) else $error("bidir input read not pin level");

   // alternate mode still reads back the stored bit
   property p_grp3_alt;
      (s_read_three and fn_code(group_three_function_control, BIDIR_BIT) == FN_ALTERNATE)
         |=> bus_rsp.rdata[BIDIR_BIT] == $past(bidir_r);
   endproperty
   a_grp3_alt: assert property (p_grp3_alt) else $error("alternate mode read not stored bit");

   // reserved code on a group three input bit reads low
   property p_grp3_reserved;
      (s_read_three and fn_code(group_three_function_control, 6) == FN_OUTPUT) |=> bus_rsp.rdata[6] == 1'b0;
   endproperty
   a_grp3_reserved: assert property (p_grp3_reserved) else $error("group three reserved read not zero");

   // a read of no register answers with zero
   property p_unmapped;
      (bus_req.rd && !sel_one && !sel_two && !sel_three) |=> bus_rsp.rdata == UNMAPPED_RDATA;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // read data only moves on a read strobe
   property p_rdata_hold;
      !bus_req.rd |=> $stable(bus_rsp.rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

   // pull-up comes on one cycle after the pull-up input code
   property p_pullup_on;
      fn_code(group_two_function_control, 0) == FN_INPUT_PULLUP |=> group_two_pullup_en[0];
   endproperty
   a_pullup_on: assert property (p_pullup_on) else $error("pull-up not enabled");

   // any other code turns the pull-up off
   property p_pullup_off;
      fn_code(group_three_function_control, 0) != FN_INPUT_PULLUP |=> !group_three_pullup_en[0];
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-up not disabled");

   // outside output mode the bidir pin is left alone
   property p_released;
      !bidir_out_mode |-> group_three_bidir_pin_oe_b;
   endproperty
   a_released: assert property (p_released) else $error("bidir pin driven outside output mode");

endmodule : port_data_regs
`default_nettype wire

// file: shared/port_data_pkg.sv
// constants, bus carriers and behaviour notes for the input-mostly port data registers
// Notes on behaviour
// - group one: eight input-only pins with pull-ups
// - group one register: eight bits, read-only, bitwise
// - general input read returns sampled pin level
// - power-on: inputs with pull-up, reads show pins
// - input-only data bits discard every write
// - group two: five io-capable, three input pins
// - group two register: eight bits read-only, undefined
// - group three: one bidirectional, seven input pins
// - group three bit seven writable, reset zero
// - output mode drives stored bit onto pin
// - output mode read returns stored bit
// - non-output mode write still updates stored bit
// - stored bit survives everything but power-on reset
// - group three low bits read low unless input
// - decode physical address, alias when untranslated
package port_data_pkg;

   // ======================================================================
   // register addresses
   localparam logic [31:0] ADDR_GROUP_ONE = 32'h0400012a; // input_group_one_levels
   localparam logic [31:0] ADDR_GROUP_TWO = 32'h0400012c; // input_group_two_levels
   localparam logic [31:0] ADDR_GROUP_THREE = 32'h0400012e; // mixed_group_three_data
   localparam logic [31:0] ALIAS_REGION_BITS = 32'ha0000000; // uncached alias region bits
   localparam logic [31:0] PHYS_ADDR_MASK = 32'h1fffffff; // strips the region bits

   // ======================================================================
   // field layout and reset values
   localparam int PIN_COUNT = 8; // pins per group
   localparam int FN_FIELD_WIDTH = 2; // function code width per pin
   localparam int BIDIR_BIT = 7; // group_three_bidir_bit position
   localparam logic BIDIR_RESET = 1'b0; // stored bit after power-on
   localparam logic [7:0] PULLUP_RESET = 8'hff; // pull-ups on after power-on
   localparam logic [7:0] RDATA_RESET = 8'h00; // read data after reset
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00; // answer to unmapped reads

   // ======================================================================
   // per-pin function codes
   localparam logic [1:0] FN_ALTERNATE = 2'h0; // other function
   localparam logic [1:0] FN_OUTPUT = 2'h1; // output, reserved on input-only pins
   localparam logic [1:0] FN_INPUT_PULLUP = 2'h2; // input, pull-up on
   localparam logic [1:0] FN_INPUT_PLAIN = 2'h3; // input, pull-up off

   // ======================================================================
   // register bus carriers
   typedef struct packed {
      logic [31:0] addr; // byte address
      logic rd; // one-cycle read strobe
      logic wr; // one-cycle write strobe
      logic [7:0] wdata; // write byte
   } bus_req_t;

   typedef struct packed {
      logic ack; // one-cycle answer pulse
      logic [7:0] rdata; // read byte, held until next read
   } bus_rsp_t;

endpackage : port_data_pkg

// file: core/pin_sync.sv
// two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ======================================================================
   // elaboration check
   if (WIDTH < 1) begin : g_width_check
      $error("pin_sync width must be at least one");
   end

   // ======================================================================
   // stages
   logic [WIDTH-1:0] meta_r; // first stage, read only by the second

   // first stage catches the pin, second one feeds logic
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : pin_sync
`default_nettype wire

// file: bench/pin_world.sv
// pin-side model: outside drivers, pull-ups and the bidirectional wire
`timescale 1ns/1ps
`default_nettype none
module pin_world (
   input wire logic clk,
   input wire logic [23:0] ext_level, // levels driven from outside, group one in the low byte
   input wire logic [23:0] ext_en, // high where the outside drives a pin
   input wire logic [23:0] pullup_en, // pull-up enables from the block
   input wire logic bidir_out, // level the block offers on the bidir pin
   input wire logic bidir_oe_b, // low while the block drives the bidir pin
   output logic [23:0] pins // resolved levels fed back to the block
);
   // ======================================================================
   // floating lines
   logic float_r = 1'b0; // toggles so a floating pin never shows a stale level
   // free-running toggle, a pin nobody holds reads as noise
   always @(posedge clk) begin
      float_r <= ~float_r;
   end
   // ======================================================================
   // wire resolution, the block wins on the bidir pin while enabled
   always_comb begin
      for (int i = 0; i < 24; i++) begin
         if (i == 23 && !bidir_oe_b) begin
            pins[i] = bidir_out;
         end else if (ext_en[i]) begin
            pins[i] = ext_level[i];
         end else if (pullup_en[i]) begin
            pins[i] = 1'b1;
         end else begin
            pins[i] = float_r ^ i[0];
         end
      end
   end
endmodule : pin_world
`default_nettype wire

// file: bench/input_mostly_port_data_regs_tb.sv
// self-checking bench for the input-mostly port data registers
`timescale 1ns/1ps
`default_nettype none
module input_mostly_port_data_regs_tb;
   import port_data_pkg::*;
   // ======================================================================
   // stimulus and observed signals
   logic clk = 1'b0; // 40 MHz
   logic rst_b = 1'b0; // power-on reset, active low
   bus_req_t req = '0; // register requests
   bus_rsp_t rsp; // registered answers
   logic xlate = 1'b0; // high when untranslated alias is decoded
   logic [15:0] ctl1 = 16'haaaa, ctl2 = 16'haaaa, ctl3 = 16'haaaa; // function codes
   logic [23:0] ext_level = 24'h5a3cc3, ext_en = 24'hffffff, pins; // pin side
   logic pin_out, oe_b; // bidir pin drive
   logic [7:0] pu1, pu2, pu3; // pull-up enables
   logic stored = 1'b0; // expected stored bidir bit
   logic [31:0] addr; // random access address
   logic [7:0] d, v; // write byte, read byte
   int n_mismatch = 0, n_compared = 0, seed = 32'hc50c, idx;
   logic alias_on, mapped;
   always #12.5 clk = ~clk;
   port_data_regs port_data_regs_inst (.clk(clk), .rst_b(rst_b), .bus_req(req), .bus_rsp(rsp),
      .addr_xlate_off(xlate), .group_one_function_control(ctl1), .group_two_function_control(ctl2),
      .group_three_function_control(ctl3), .group_one_pins(pins[7:0]), .group_two_pins(pins[15:8]),
      .group_three_pins(pins[23:16]), .group_three_bidir_pin_out(pin_out),
      .group_three_bidir_pin_oe_b(oe_b), .group_one_pullup_en(pu1), .group_two_pullup_en(pu2),
      .group_three_pullup_en(pu3));
   pin_world pin_world_inst (.clk(clk), .ext_level(ext_level), .ext_en(ext_en),
      .pullup_en({pu3, pu2, pu1}), .bidir_out(pin_out), .bidir_oe_b(oe_b), .pins(pins));
   // ======================================================================
   // expectation helpers
   // read view: pin when code 1x, stored bit on the bidir bit, else low
   function automatic logic [7:0] view(input logic [15:0] c, input logic [7:0] p, input logic bidir);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = c[2*i+1] ? p[i] : ((bidir && i == 7) ? stored : 1'b0);
      end
      return r;
   endfunction : view
   // pull-up on only for code 10
   function automatic logic [7:0] pull(input logic [15:0] c);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = (c[2*i+:2] == 2'b10);
      end
      return r;
   endfunction : pull
   // expected byte at register index, index 3 is unmapped
   function automatic logic [7:0] exp_reg(input int k);
      case (k)
         0: return view(ctl1, pins[7:0], 1'b0);
         1: return view(ctl2, pins[15:8], 1'b0);
         2: return view(ctl3, pins[23:16], 1'b1);
         default: return 8'h00;
      endcase
   endfunction : exp_reg
   function automatic logic [31:0] reg_addr(input int k);
      return (k == 0) ? ADDR_GROUP_ONE : (k == 1) ? ADDR_GROUP_TWO : (k == 2) ? ADDR_GROUP_THREE : 32'h04000131;
   endfunction : reg_addr
   // ======================================================================
   // comparison, bus cycle and verdict
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one-cycle strobe, answer looked at one cycle later
   task automatic access(input logic [31:0] a, input logic w, input logic [7:0] wd);
      @(negedge clk);
      req.addr = a;
      req.rd = !w;
      req.wr = w;
      req.wdata = wd;
      @(negedge clk);
      req.rd = 1'b0;
      req.wr = 1'b0;
      check("ack", {7'h00, rsp.ack}, 8'h01);
      v = rsp.rdata;
   endtask : access
   task automatic settle();
      repeat (5) @(negedge clk);
   endtask : settle
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   // ======================================================================
   // watchdog, generous against about 950 cycles of tests
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
   // ======================================================================
   // main sequence
   initial begin
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      settle();
      check("pullups", pu1 & pu2 & pu3, 8'hff);
      check("pin_out", {7'h00, pin_out}, 8'h00);
      for (int k = 0; k < 3; k++) begin
         access(reg_addr(k), 1'b0, 8'h00);
         check("reset read", v, pins[8*k+:8]);
      end
      // all pins released, pull-ups hold them high
      ext_en = 24'h000000;
      settle();
      for (int k = 0; k < 3; k++) begin
         access(reg_addr(k), 1'b0, 8'h00);
         check("pulled read", v, 8'hff);
      end
      ext_en = 24'hffffff;
      // random codes, pins, writes and alias accesses
      for (int n = 0; n < 60; n++) begin
         ctl1 = 16'($random(seed));
         ctl2 = 16'($random(seed));
         ctl3 = 16'($random(seed));
         ext_level = 24'($random(seed));
         ext_en[23] = (ctl3[15:14] != FN_OUTPUT);
         xlate = 1'($random(seed));
         idx = $unsigned($random(seed)) % 4;
         alias_on = 1'($random(seed));
         d = 8'($random(seed));
         settle();
         check("pu1", pu1, pull(ctl1));
         check("pu2", pu2, pull(ctl2));
         check("pu3", pu3, pull(ctl3));
         check("oe_b", {7'h00, oe_b}, {7'h00, ctl3[15:14] != FN_OUTPUT});
         addr = reg_addr(idx) | (alias_on ? ALIAS_REGION_BITS : 32'h0);
         mapped = (idx < 3) && (!alias_on || xlate);
         access(addr, 1'b1, d);
         if (mapped && idx == 2) begin
            stored = d[7];
         end
         check("pin_out", {7'h00, pin_out}, {7'h00, stored});
         access(ADDR_GROUP_ONE, 1'b0, 8'h00);
         check("group one", v, exp_reg(0));
         access(ADDR_GROUP_TWO, 1'b0, 8'h00);
         check("group two", v, exp_reg(1));
         access(ADDR_GROUP_THREE, 1'b0, 8'h00);
         check("group three", v, exp_reg(2));
         access(addr, 1'b0, 8'h00);
         check("decoded read", v, mapped ? exp_reg(idx) : 8'h00);
      end
      // stored bit set, then a power-on reset in mid-run clears it
      ctl3 = 16'haaaa;
      access(ADDR_GROUP_THREE, 1'b1, 8'h80);
      check("kept bit", {7'h00, pin_out}, 8'h01);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      stored = 1'b0;
      settle();
      check("cleared bit", {7'h00, pin_out}, 8'h00);
      print_verdict();
   end
endmodule : input_mostly_port_data_regs_tb
`default_nettype wire
